// file: pkg/agp_pkg.sv
// shared constants, states and carriers of the access group descriptor parser
package agp_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_GROUP_ID = 8'h0C;
  localparam logic [7:0] OFF_SYS_ID = 8'h10;
  localparam logic [7:0] OFF_CIPHER = 8'h14;
  localparam logic [7:0] OFF_STATE = 8'h18;

  // control fields and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_LIST_BIT = 1;
  localparam int CTRL_W = 2;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int EV_W = 4;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [3:0] STATUS_RST = 4'h0;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // descriptor layout
  // ****************************************
  localparam logic [7:0] TAG_CIPHER = 8'hCB;
  localparam logic [7:0] TAG_GROUP = 8'hCC;
  localparam logic [7:0] GID_LAST = 8'h03;
  localparam logic [7:0] SYS_LAST = 8'h01;
  // id 4 + system 2 + four length bytes
  localparam logic [7:0] GROUP_MIN_LEN = 8'h0A;
  localparam logic [7:0] CIPHER_MIN_LEN = 8'h01;

  // string kinds, in the order they appear
  localparam logic [1:0] KIND_LICENCE = 2'h0;
  localparam logic [1:0] KIND_FEE = 2'h1;
  localparam logic [1:0] KIND_FIRST = 2'h2;
  localparam logic [1:0] KIND_VENDOR = 2'h3;

  typedef enum logic [10:0] {
    ST_IDLE = 11'h001,
    ST_LEN_HI = 11'h002,
    ST_LEN_LO = 11'h004,
    ST_TAG = 11'h008,
    ST_DLEN = 11'h010,
    ST_GID = 11'h020,
    ST_SYS = 11'h040,
    ST_SLEN = 11'h080,
    ST_SDATA = 11'h100,
    ST_CIPH = 11'h200,
    ST_SKIP = 11'h400
  } agp_state_e;

  // one byte of an extracted string
  typedef struct packed {
    logic valid;
    logic last;
    logic [1:0] kind;
    logic [7:0] data;
  } agp_str_s;

  // event pulses, group in bit 0
  typedef struct packed {
    logic err;
    logic list;
    logic cipher;
    logic group;
  } agp_evt_s;

endpackage

// file: verif/agp_parser_bench.sv
// self-checking bench of the descriptor parser
`timescale 1ns/1ps
module agp_parser_bench;
  typedef logic [7:0] agp_bytes_t[$];
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [2:0] s_axi_arprot = 3'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic in_valid;
  logic in_sof;
  logic [7:0] in_data;
  logic in_ready;
  logic [31:0] access_group_id;
  logic [15:0] playback_system_id;
  logic [7:0] cipher_selector;
  agp_pkg::agp_str_s str_out;
  agp_pkg::agp_evt_s evt_out;
  logic irq;
  int n_mismatch = 0;
  int cmp_count = 0;
  int ev[4] = '{0, 0, 0, 0};
  int cyc = 0;
  logic [10:0] sq[$];
  agp_parser agp_parser_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .in_valid, .in_sof, .in_data,
    .in_ready, .access_group_id, .playback_system_id, .cipher_selector, .str_out, .evt_out,
    .irq);
  agp_src_model agp_src_model_inst (.aclk, .in_ready, .in_valid, .in_sof, .in_data);
  always #25 aclk = ~aclk;
  // ****
  // checking helpers
  // ****
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // a hang is cut short well past the longest sequence
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  // pulses stand one cycle, so collect them at every edge
  always @(posedge aclk)
  begin
    if (str_out.valid === 1'b1)
      sq.push_back({str_out.last, str_out.kind, str_out.data});
    for (int i = 0; i < 4; i++)
      ev[i] += int'(evt_out[i] === 1'b1);
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er), "bresp");
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e, "rdata");
    chk(32'(s_axi_rresp), 32'(er), "rresp");
    @(posedge aclk);
  endtask
  // one unit, first byte marked; waits until every byte is taken
  task automatic snd(input agp_bytes_t b);
    int n;
    sq.delete();
    ev = '{0, 0, 0, 0};
    foreach (b[i])
      agp_src_model_inst.put(b[i], i == 0);
    n = 0;
    while ((agp_src_model_inst.q.size() != 0 || in_valid === 1'b1) && n < 500)
    begin
      @(posedge aclk);
      n++;
    end
    repeat (2) @(posedge aclk);
  endtask
  task automatic evs(input int g, input int c, input int l, input int e);
    chk(ev[0], g, "group events");
    chk(ev[1], c, "cipher events");
    chk(ev[2], l, "list events");
    chk(ev[3], e, "error events");
  endtask
  // ****
  // test sequence
  // ****
  initial
  begin
    logic [10:0] xs[$];
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++)
      rd(8'(4 * i), (i == 6) ? 32'h1 : 32'h0, agp_pkg::RESP_OKAY);
    rd(8'h1C, 32'h0, agp_pkg::RESP_SLVERR);
    wr(8'h20, 32'h1, agp_pkg::RESP_SLVERR);
    wr(agp_pkg::OFF_GROUP_ID, 32'h5, agp_pkg::RESP_OKAY);
    rd(agp_pkg::OFF_GROUP_ID, 32'h0, agp_pkg::RESP_OKAY);
    wr(agp_pkg::OFF_MASK, 32'hF, agp_pkg::RESP_OKAY);
    wr(agp_pkg::OFF_CTRL, 32'h1, agp_pkg::RESP_OKAY);
    agp_src_model_inst.gap = 2;
    snd('{8'hCC, 8'h10, 8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'h12, 8'h34, 8'h02, 8'h41, 8'h42,
      8'h01, 8'h46, 8'h01, 8'h43, 8'h02, 8'h56, 8'h57});
    agp_src_model_inst.gap = 0;
    xs = '{11'h041, 11'h442, 11'h546, 11'h643, 11'h356, 11'h757};
    chk(sq.size(), 6, "string bytes");
    foreach (xs[i])
      chk(32'(sq[i]), 32'(xs[i]), "string byte");
    chk(access_group_id, 32'hA1B2C3D4, "group id");
    chk(32'(playback_system_id), 32'h1234, "system id");
    evs(1, 0, 0, 0);
    chk(32'(irq), 32'h1, "irq set");
    rd(agp_pkg::OFF_STATUS, 32'h1, agp_pkg::RESP_OKAY);
    chk(32'(irq), 32'h0, "irq clear");
    rd(agp_pkg::OFF_SYS_ID, 32'h1234, agp_pkg::RESP_OKAY);
    snd('{8'hCC, 8'h09, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    evs(0, 0, 0, 1);
    snd('{8'hCC, 8'h0A, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h02, 8'h05, 8'h41, 8'h42,
      8'h43});
    evs(0, 0, 0, 1);
    snd('{8'hC0, 8'h01, 8'h99});
    evs(0, 0, 0, 0);
    snd('{8'hCB, 8'h01, 8'h5A});
    chk(32'(cipher_selector), 32'h5A, "cipher");
    evs(0, 1, 0, 0);
    rd(agp_pkg::OFF_STATUS, 32'hA, agp_pkg::RESP_OKAY);
    wr(agp_pkg::OFF_MASK, 32'h0, agp_pkg::RESP_OKAY);
    snd('{8'hCB, 8'h01, 8'h3C});
    chk(32'(irq), 32'h0, "irq masked");
    rd(agp_pkg::OFF_CIPHER, 32'h3C, agp_pkg::RESP_OKAY);
    rd(agp_pkg::OFF_STATUS, 32'h2, agp_pkg::RESP_OKAY);
    wr(agp_pkg::OFF_MASK, 32'hF, agp_pkg::RESP_OKAY);
    wr(agp_pkg::OFF_CTRL, 32'h3, agp_pkg::RESP_OKAY);
    snd('{8'h00, 8'h18, 8'hCC, 8'h0A, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h09, 8'h00, 8'h00,
      8'h00, 8'h00, 8'hCC, 8'h0A, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h09, 8'h00, 8'h00,
      8'h00, 8'h00, 8'hCC, 8'h0A, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h00, 8'h09, 8'h00, 8'h00,
      8'h00, 8'h00});
    evs(2, 0, 1, 0);
    chk(access_group_id, 32'h8, "list stop");
    snd('{8'h00, 8'h03, 8'hCB, 8'h01, 8'h77});
    chk(ev[3], 1, "list tag");
    chk(ev[2], 1, "list tag end");
    chk(32'(cipher_selector), 32'h3C, "list cipher");
    // descriptor longer than the list rest: the list rest is skipped
    snd('{8'h00, 8'h03, 8'hCC, 8'h05, 8'h00});
    evs(0, 0, 1, 1);
    // a unit cut short is dropped when the next start byte restarts the walk
    snd('{8'h00, 8'h10, 8'hCB});
    snd('{8'h00, 8'h00});
    evs(0, 0, 1, 0);
    wr(agp_pkg::OFF_CTRL, 32'h0, agp_pkg::RESP_OKAY);
    chk(32'(in_ready), 32'h0, "disabled");
    rd(agp_pkg::OFF_STATE, 32'h1, agp_pkg::RESP_OKAY);
    stop_test();
  end
endmodule

// file: verif/agp_parser_monitor.sv
// checker of the descriptor parser port behaviour
`timescale 1ns/1ps
module agp_parser_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic [7:0] in_data,
  input wire logic [31:0] access_group_id,
  input wire logic [15:0] playback_system_id,
  input wire logic [7:0] cipher_selector,
  input wire agp_pkg::agp_str_s str_out,
  input wire agp_pkg::agp_evt_s evt_out,
  input wire logic irq
);
  // ****
  // assertions
  // ****
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a string byte is the byte taken one edge earlier, unchanged
  property p_str_byte;
    str_out.valid |-> $past(in_valid && in_ready) && str_out.data == $past(in_data);
  endproperty
  a_str_byte: assert property (p_str_byte) else $error("string byte");
  property p_group_end;
    str_out.valid && str_out.last && str_out.kind == agp_pkg::KIND_VENDOR |-> evt_out.group;
  endproperty
  a_group_end: assert property (p_group_end) else $error("group end");
  // ids shift in msb first, so the low byte is always the last one taken
  property p_gid;
    $changed(access_group_id) |-> access_group_id[7:0] == $past(in_data);
  endproperty
  a_gid: assert property (p_gid) else $error("group id");
  property p_sys;
    $changed(playback_system_id) |-> playback_system_id[7:0] == $past(in_data);
  endproperty
  a_sys: assert property (p_sys) else $error("system id");
  property p_cipher;
    evt_out.cipher |-> cipher_selector == $past(in_data) && $past(in_valid && in_ready);
  endproperty
  a_cipher: assert property (p_cipher) else $error("cipher");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer");
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer");
  // irq may only drop on a status read or a register write
  property p_irq_fall;
    $fell(irq) |-> $past(s_axi_arvalid && s_axi_arready) || $rose(s_axi_bvalid);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fall");
endmodule
bind agp_parser agp_parser_monitor agp_parser_monitor_inst (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .in_valid, .in_ready, .in_data, .access_group_id, .playback_system_id,
  .cipher_selector, .str_out, .evt_out, .irq);

// file: verif/agp_src_model.sv
// upstream byte source model feeding the parser stream
`timescale 1ns/1ps
module agp_src_model (
  input wire logic aclk,
  input wire logic in_ready,
  output logic in_valid,
  output logic in_sof,
  output logic [7:0] in_data
);
  logic [8:0] q[$];
  int gap = 0;
  int idle_n = 0;
  initial
  begin
    in_valid = 1'b0;
    in_sof = 1'b0;
    in_data = 8'h00;
  end
  // start of a unit is carried in bit 8 beside each byte, so every unit is queued alike
  task automatic put(input logic [7:0] b, input logic s);
    q.push_back({s, b});
  endtask
  // a byte stands until taken; idle data toggles so stale bytes never look valid
  always @(posedge aclk)
  begin
    if (in_valid && in_ready)
    begin
      void'(q.pop_front());
      idle_n = gap;
    end
    if (!in_valid || in_ready)
    begin
      if (q.size() != 0 && idle_n == 0)
      begin
        in_valid <= 1'b1;
        in_sof <= q[0][8];
        in_data <= q[0][7:0];
      end
      else
      begin
        if (idle_n > 0)
          idle_n--;
        in_valid <= 1'b0;
        in_sof <= 1'b0;
        in_data <= ~in_data;
      end
    end
  end
endmodule

// file: verilog/agp_parser.sv
// byte-serial parser for group, cipher descriptors and stored group lists
`timescale 1ns/1ps
module agp_parser (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic in_valid,
  input wire logic in_sof,
  input wire logic [7:0] in_data,
  output logic in_ready,
  output logic [31:0] access_group_id,
  output logic [15:0] playback_system_id,
  output logic [7:0] cipher_selector,
  output agp_pkg::agp_str_s str_out,
  output agp_pkg::agp_evt_s evt_out,
  output logic irq
);

  // ****************************************
  // parser state
  // ****************************************
  agp_pkg::agp_state_e state_ff, nxt_state, cur;
  logic [7:0] desc_rem_ff, nxt_desc_rem;
  logic [15:0] list_rem_ff, nxt_list_rem;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [1:0] kind_ff, nxt_kind;
  logic [7:0] tag_ff, nxt_tag;
  logic [23:0] gid_sh_ff, nxt_gid_sh;
  logic [7:0] sys_hi_ff, nxt_sys_hi;
  logic list_active_ff, nxt_list_active;
  logic skip_list_ff, nxt_skip_list;
  logic gid_we, sys_we, ciph_we, fin, str_end, acc, lst;
  logic [7:0] dr;
  logic [15:0] lr;
  logic [8:0] need;
  agp_pkg::agp_str_s nxt_str;
  agp_pkg::agp_evt_s ev;

  // registers seen by software
  logic [agp_pkg::CTRL_W-1:0] ctrl_ff;
  logic [agp_pkg::EV_W-1:0] status_ff, mask_ff, nxt_status;
  logic [31:0] gid_ff;
  logic [15:0] sys_ff;
  logic [7:0] ciph_ff;
  agp_pkg::agp_str_s str_ff;
  agp_pkg::agp_evt_s evt_ff;
  logic ctrl_en, list_mode;

  // bus side
  logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic do_wr, ar_hs, rd_clr;

  // an address is mapped when it is one of the word registers
  function automatic logic reg_known(input logic [7:0] a);
    reg_known = (a == agp_pkg::OFF_CTRL) || (a == agp_pkg::OFF_STATUS) ||
                (a == agp_pkg::OFF_MASK) || (a == agp_pkg::OFF_GROUP_ID) ||
                (a == agp_pkg::OFF_SYS_ID) || (a == agp_pkg::OFF_CIPHER) ||
                (a == agp_pkg::OFF_STATE);
  endfunction

  assign ctrl_en = ctrl_ff[agp_pkg::CTRL_EN_BIT];
  assign list_mode = ctrl_ff[agp_pkg::CTRL_LIST_BIT];

  // ****************************************
  // byte walk
  // ****************************************
  // upstream is same-clock logic; stalling only happens while disabled
  assign in_ready = ctrl_en;
  assign acc = in_valid & ctrl_en;
  // a start-of-unit byte restarts the walk whatever the current state
  assign cur = in_sof ? (list_mode ? agp_pkg::ST_LEN_HI : agp_pkg::ST_TAG) : state_ff;
  assign lst = in_sof ? 1'b0 : list_active_ff;
  assign dr = desc_rem_ff - 8'h01;
  assign lr = list_rem_ff - 16'h0001;
  // string length plus the length bytes still to come must fit
  assign need = {1'b0, in_data} + {7'h00, agp_pkg::KIND_VENDOR - kind_ff};

  always_comb
  begin
    nxt_state = state_ff;
    nxt_desc_rem = desc_rem_ff;
    nxt_list_rem = list_rem_ff;
    nxt_cnt = cnt_ff;
    nxt_kind = kind_ff;
    nxt_tag = tag_ff;
    nxt_gid_sh = gid_sh_ff;
    nxt_sys_hi = sys_hi_ff;
    nxt_list_active = list_active_ff;
    nxt_skip_list = skip_list_ff;
    nxt_str = '0;
    ev = '0;
    gid_we = 1'b0;
    sys_we = 1'b0;
    ciph_we = 1'b0;
    fin = 1'b0;
    str_end = 1'b0;
    if (acc)
    begin
      // every byte inside a list counts down the list length
      if (lst)
        nxt_list_rem = lr;
      unique case (cur)
        agp_pkg::ST_IDLE: ; // stray bytes between units are dropped
        agp_pkg::ST_LEN_HI:
        begin
          nxt_list_rem = {in_data, list_rem_ff[7:0]};
          nxt_list_active = 1'b0;
          nxt_state = agp_pkg::ST_LEN_LO;
        end
        agp_pkg::ST_LEN_LO:
        begin
          nxt_list_rem = {list_rem_ff[15:8], in_data};
          if ({list_rem_ff[15:8], in_data} == 16'h0000)
          begin
            ev.list = 1'b1;
            nxt_state = agp_pkg::ST_IDLE;
          end
          else
          begin
            nxt_list_active = 1'b1;
            nxt_state = agp_pkg::ST_TAG;
          end
        end
        agp_pkg::ST_TAG:
        begin
          nxt_tag = in_data;
          nxt_skip_list = 1'b0;
          nxt_state = agp_pkg::ST_DLEN;
        end
        agp_pkg::ST_DLEN:
        begin
          nxt_desc_rem = in_data;
          nxt_cnt = 8'h00;
          nxt_kind = agp_pkg::KIND_LICENCE;
          if (lst && ({8'h00, in_data} > lr))
          begin
            // descriptor claims more than the list holds: drop the list rest
            ev.err = 1'b1;
            if (lr == 16'h0000)
              fin = 1'b1;
            else
            begin
              nxt_skip_list = 1'b1;
              nxt_state = agp_pkg::ST_SKIP;
            end
          end
          else if ((lst && tag_ff != agp_pkg::TAG_GROUP) ||
                   (tag_ff == agp_pkg::TAG_GROUP && in_data < agp_pkg::GROUP_MIN_LEN) ||
                   (tag_ff == agp_pkg::TAG_CIPHER && in_data < agp_pkg::CIPHER_MIN_LEN))
          begin
            ev.err = 1'b1;
            if (in_data == 8'h00)
              fin = 1'b1;
            else
              nxt_state = agp_pkg::ST_SKIP;
          end
          else if (in_data == 8'h00)
            fin = 1'b1;
          else if (tag_ff == agp_pkg::TAG_GROUP)
            nxt_state = agp_pkg::ST_GID;
          else if (tag_ff == agp_pkg::TAG_CIPHER)
            nxt_state = agp_pkg::ST_CIPH;
          else
            nxt_state = agp_pkg::ST_SKIP;
        end
        agp_pkg::ST_GID:
        begin
          nxt_desc_rem = dr;
          nxt_gid_sh = {gid_sh_ff[15:0], in_data};
          nxt_cnt = cnt_ff + 8'h01;
          if (cnt_ff == agp_pkg::GID_LAST)
          begin
            gid_we = 1'b1;
            nxt_cnt = 8'h00;
            nxt_state = agp_pkg::ST_SYS;
          end
        end
        agp_pkg::ST_SYS:
        begin
          nxt_desc_rem = dr;
          nxt_sys_hi = in_data;
          nxt_cnt = cnt_ff + 8'h01;
          if (cnt_ff == agp_pkg::SYS_LAST)
          begin
            sys_we = 1'b1;
            nxt_cnt = 8'h00;
            nxt_state = agp_pkg::ST_SLEN;
          end
        end
        agp_pkg::ST_SLEN:
        begin
          nxt_desc_rem = dr;
          if (need > {1'b0, dr})
          begin
            ev.err = 1'b1;
            if (dr == 8'h00)
              fin = 1'b1;
            else
              nxt_state = agp_pkg::ST_SKIP;
          end
          else if (in_data == 8'h00)
            str_end = 1'b1;
          else
          begin
            nxt_cnt = in_data;
            nxt_state = agp_pkg::ST_SDATA;
          end
        end
        agp_pkg::ST_SDATA:
        begin
          nxt_desc_rem = dr;
          nxt_cnt = cnt_ff - 8'h01;
          nxt_str.valid = 1'b1;
          nxt_str.kind = kind_ff;
          nxt_str.data = in_data;
          nxt_str.last = (cnt_ff == 8'h01);
          if (cnt_ff == 8'h01)
            str_end = 1'b1;
        end
        agp_pkg::ST_CIPH:
        begin
          nxt_desc_rem = dr;
          ciph_we = 1'b1;
          ev.cipher = 1'b1;
          if (dr == 8'h00)
            fin = 1'b1;
          else
            nxt_state = agp_pkg::ST_SKIP;
        end
        agp_pkg::ST_SKIP:
        begin
          nxt_desc_rem = dr;
          if (skip_list_ff ? (lr == 16'h0000) : (dr == 8'h00))
            fin = 1'b1;
        end
        default:
          nxt_state = agp_pkg::ST_IDLE;
      endcase
      // a string ended: step to the next one or close the group body
      if (str_end)
      begin
        if (kind_ff == agp_pkg::KIND_VENDOR)
        begin
          ev.group = 1'b1;
          if (dr == 8'h00)
            fin = 1'b1;
          else
            nxt_state = agp_pkg::ST_SKIP;
        end
        else
        begin
          nxt_kind = kind_ff + 2'h1;
          nxt_state = agp_pkg::ST_SLEN;
        end
      end
      // descriptor done: next entry of the list, or back to idle
      if (fin)
      begin
        if (lst && lr != 16'h0000)
          nxt_state = agp_pkg::ST_TAG;
        else
        begin
          if (lst)
            ev.list = 1'b1;
          nxt_list_active = 1'b0;
          nxt_state = agp_pkg::ST_IDLE;
        end
      end
    end
  end

  // walk registers; disabling parks the walk in idle
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ctrl_en)
    begin
      state_ff <= agp_pkg::ST_IDLE;
      list_active_ff <= 1'b0;
      skip_list_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      list_active_ff <= nxt_list_active;
      skip_list_ff <= nxt_skip_list;
    end
  end

  // counters and field accumulators
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      desc_rem_ff <= 8'h00;
      list_rem_ff <= 16'h0000;
      cnt_ff <= 8'h00;
      kind_ff <= agp_pkg::KIND_LICENCE;
      tag_ff <= 8'h00;
      gid_sh_ff <= 24'h000000;
      sys_hi_ff <= 8'h00;
    end
    else
    begin
      desc_rem_ff <= nxt_desc_rem;
      list_rem_ff <= nxt_list_rem;
      cnt_ff <= nxt_cnt;
      kind_ff <= nxt_kind;
      tag_ff <= nxt_tag;
      gid_sh_ff <= nxt_gid_sh;
      sys_hi_ff <= nxt_sys_hi;
    end
  end

  // ****************************************
  // extracted fields and string stream
  // ****************************************
  // ids change only on their last byte, so readers never see half a word
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gid_ff <= 32'h00000000;
      sys_ff <= 16'h0000;
      ciph_ff <= 8'h00;
      str_ff <= '0;
      evt_ff <= '0;
    end
    else
    begin
      if (gid_we)
        gid_ff <= {gid_sh_ff, in_data};
      if (sys_we)
        sys_ff <= {sys_hi_ff, in_data};
      if (ciph_we)
        ciph_ff <= in_data;
      str_ff <= nxt_str;
      evt_ff <= ev;
    end
  end

  assign access_group_id = gid_ff;
  assign playback_system_id = sys_ff;
  assign cipher_selector = ciph_ff;
  assign str_out = str_ff;
  assign evt_out = evt_ff;

  // ****************************************
  // status, mask and interrupt
  // ****************************************
  // a new event in the clearing read cycle survives: set beats clear
  assign nxt_status = (rd_clr ? agp_pkg::STATUS_RST : status_ff) | ev;
  assign irq = |(status_ff & mask_ff);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_ff <= agp_pkg::STATUS_RST;
    else
      status_ff <= nxt_status;
  end

  // ****************************************
  // bus slave
  // ****************************************
  // address and data are held separately so either may arrive first
  assign s_axi_awready = !aw_hold_ff;
  assign s_axi_wready = !w_hold_ff;
  assign do_wr = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign ar_hs = s_axi_arvalid && !rvalid_ff;
  assign rd_clr = ar_hs && (s_axi_araddr == agp_pkg::OFF_STATUS);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= agp_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_hold_ff)
      begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_ff)
      begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= reg_known(awaddr_ff) ? agp_pkg::RESP_OKAY : agp_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  // writable registers; fields sit in byte lane 0
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_ff <= agp_pkg::CTRL_RST;
      mask_ff <= agp_pkg::MASK_RST;
    end
    else if (do_wr && wstrb_ff[0])
    begin
      if (awaddr_ff == agp_pkg::OFF_CTRL)
        ctrl_ff <= wdata_ff[agp_pkg::CTRL_W-1:0];
      if (awaddr_ff == agp_pkg::OFF_MASK)
        mask_ff <= wdata_ff[agp_pkg::EV_W-1:0];
    end
  end

  // read data is latched at the address handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= agp_pkg::RESP_OKAY;
    end
    else if (ar_hs)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff <= reg_known(s_axi_araddr) ? agp_pkg::RESP_OKAY : agp_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        agp_pkg::OFF_CTRL: rdata_ff <= {30'h00000000, ctrl_ff};
        agp_pkg::OFF_STATUS: rdata_ff <= {28'h0000000, status_ff};
        agp_pkg::OFF_MASK: rdata_ff <= {28'h0000000, mask_ff};
        agp_pkg::OFF_GROUP_ID: rdata_ff <= gid_ff;
        agp_pkg::OFF_SYS_ID: rdata_ff <= {16'h0000, sys_ff};
        agp_pkg::OFF_CIPHER: rdata_ff <= {24'h000000, ciph_ff};
        agp_pkg::OFF_STATE: rdata_ff <= {20'h00000, list_active_ff, state_ff};
        default: rdata_ff <= 32'h00000000;
      endcase
    end
    else if (s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

endmodule
